// ### src/sp4u_pkg.sv
// Constants and types shared by the four-mode serial port.
// ============================================================
// Notes on behaviour
// (RULE1) Two mode bits pick shift register, 8-bit, fixed 9-bit or variable 9-bit.
// (RULE2) 8-bit mode with multiprocessor bit set needs a valid stop bit.
// (RULE3) 9-bit modes with multiprocessor bit set drop frames whose ninth bit is 0.
// (RULE4) Frames are accepted only while receive enable is set.
// (RULE5) 9-bit modes send the transmit ninth bit field as ninth bit.
// (RULE6) Received ninth bit, or stop bit in 8-bit mode, goes to rx ninth field.
// (RULE7) Transmit done sets after bit eight or at stop start; software clears.
// (RULE8) Receive done sets after bit eight or mid stop bit; software clears.
// (RULE9) Shift mode moves eight bits LSB first on rxd, clock on txd.
// (RULE10) Shift mode receive starts when enabled and receive done is clear.
// (RULE11) Shift mode bit rate is core clock over twelve.
// (RULE12) 8-bit frame: start 0, eight data bits LSB first, stop 1.
// (RULE13) 8-bit write loads 1 in ninth position; done flag at stop bit.
// (RULE14) Async receive starts on falling rxd, skips start bit, shifts eight bits, or nine in 9-bit modes.
// (RULE15) Final shift loads buffer and flags only if receive done is clear.
// (RULE16) 9-bit frame: start 0, eight data, ninth bit, stop 1.
// (RULE17) Fixed 9-bit rate is core over 64, or over 32 when doubled.
// (RULE18) 9-bit transmit starts at next bit tick; done flag at stop bit.
// (RULE19) Variable 9-bit mode uses the variable rate source.
// (RULE20) Non-shift modes receive on a start bit while enable is set.
// (RULE21) Any write of the buffer starts a transmission.
// (RULE22) Variable rates use timer one, timer two or the dedicated generator.
// (RULE23) Buffer writes feed transmit, reads return a separate receive register.
// (RULE24) Receiver is double buffered; an unread byte may be lost.
// (RULE25) Timer two source needs sixteen overflows per bit.
// (RULE26) Start bit no longer low at mid-bit is rejected.
`default_nettype none

package sp4u_pkg;

    // ============================================================
    // Register map, byte addresses.
    localparam logic [3:0] SP4U_CTRL_OFS = 4'h0;
    localparam logic [3:0] SP4U_BUF_OFS = 4'h4;
    localparam logic [3:0] SP4U_CFG_OFS = 4'h8;
    localparam logic [3:0] SP4U_STAT_OFS = 4'hC;

    // ============================================================
    // Field positions and reset values.
    localparam int SP4U_MP_BIT = 5;
    localparam int SP4U_REN_BIT = 4;
    localparam int SP4U_TB8_BIT = 3;
    localparam int SP4U_RB8_BIT = 2;
    localparam int SP4U_TI_BIT = 1;
    localparam int SP4U_RI_BIT = 0;
    localparam int SP4U_DBL_BIT = 0;
    localparam logic [7:0] SP4U_CTRL_RST = 8'h00;
    localparam logic [4:0] SP4U_CFG_RST = 5'h00;

    // ============================================================
    // Modes and rate sources.
    typedef enum logic [1:0] {
        SP4U_MODE_SHIFT = 2'h0,
        SP4U_MODE_UART8 = 2'h1,
        SP4U_MODE_FIX9 = 2'h2,
        SP4U_MODE_VAR9 = 2'h3
    } sp4u_mode_t;

    localparam logic [1:0] SP4U_SRC_T1 = 2'h0;
    localparam logic [1:0] SP4U_SRC_T2 = 2'h1;
    localparam logic [1:0] SP4U_SRC_GEN = 2'h2;

    typedef enum logic [2:0] {
        SP4U_RX_IDLE = 3'h1,
        SP4U_RX_START = 3'h2,
        SP4U_RX_DATA = 3'h4
    } sp4u_rx_state_t;

    // ============================================================
    // Cycle counts.
    localparam logic [3:0] SP4U_M0_DIV = 4'hC;
    localparam logic [3:0] SP4U_M0_HALF = 4'h6;
    localparam logic [3:0] SP4U_OVS_LAST = 4'hF;
    localparam logic [3:0] SP4U_OVS_MID = 4'h7;
    localparam logic [3:0] SP4U_BITS8 = 4'hA;
    localparam logic [3:0] SP4U_BITS9 = 4'hB;
    localparam logic [3:0] SP4U_RX_STOP8 = 4'h8;
    localparam logic [3:0] SP4U_RX_STOP9 = 4'h9;

endpackage

`default_nettype wire

// ### src/sp4u_top.sv
// Four-mode serial port with a classic Wishbone register slave.
`default_nettype none

module sp4u_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire logic baudgen_tick_i,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o
);

    // ============================================================
    // Register storage.
    logic [7:0] serial_control_reg;
    logic [4:0] cfg_reg;
    logic [7:0] rx_buf_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic bus_req;
    logic ctrl_wr;
    logic buf_wr;
    logic ti_set;
    logic ri_set;
    logic rb8_load;
    logic rb8_value;
    logic [7:0] rx_load_data;
    sp4u_pkg::sp4u_mode_t mode;
    logic nine_bit;
    logic multiprocessor_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rate_double;

    // ============================================================
    // Rate ticks, sixteen per bit.
    logic t1_half_reg;
    logic [1:0] fix_cnt_reg;
    logic t1_tick;
    logic fix_tick;
    logic tx_tick16;
    logic rx_tick16;

    // ============================================================
    // Shift mode, transmit and receive engines.
    logic m0_busy_reg;
    logic m0_rx_reg;
    logic [3:0] m0_cnt_reg;
    logic [2:0] m0_bits_reg;
    logic [7:0] m0_shift_reg;
    logic m0_clk_reg;
    logic m0_end;
    logic tx_busy_reg;
    logic [10:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_sub_reg;
    logic tx_line_reg;
    logic tx_bit_tick;
    logic [3:0] tx_bits;
    sp4u_pkg::sp4u_rx_state_t rx_state_reg;
    logic [3:0] rx_sub_reg;
    logic [3:0] rx_cnt_reg;
    logic [8:0] rx_shift_reg;
    logic rx_mid;
    logic rx_final;
    logic rxd_meta_reg;
    logic rxd_sync_reg;
    logic rxd_prev_reg;
    logic rxd_out_reg;
    logic rxd_oe_reg;

    // Picks the sixteen-per-bit tick for one direction.
    function automatic logic pick_tick(input logic fixed, input logic [1:0] src,
                                       input logic t1, input logic t2,
                                       input logic gen, input logic fx);
        logic t;
        t = 1'b0;
        if (fixed) begin
            t = fx;
        end else begin
            case (src)
                sp4u_pkg::SP4U_SRC_T1: t = t1;
                sp4u_pkg::SP4U_SRC_T2: t = t2;
                sp4u_pkg::SP4U_SRC_GEN: t = gen;
                default: t = t1;
            endcase
        end
        return t;
    endfunction

    // (RULE1) Mode decode.
    assign mode = sp4u_pkg::sp4u_mode_t'(serial_control_reg[7:6]);
    assign nine_bit = serial_control_reg[7];
    assign multiprocessor_enable = serial_control_reg[sp4u_pkg::SP4U_MP_BIT];
    assign rx_enable = serial_control_reg[sp4u_pkg::SP4U_REN_BIT];
    assign tx_ninth_bit = serial_control_reg[sp4u_pkg::SP4U_TB8_BIT];
    assign rate_double = cfg_reg[sp4u_pkg::SP4U_DBL_BIT];

    // ============================================================
    // Wishbone slave, one wait state.
    assign bus_req = cyc_i & stb_i & ~ack_reg;
    assign ctrl_wr = bus_req & we_i & sel_i[0]
                     & (adr_i == sp4u_pkg::SP4U_CTRL_OFS);
    assign buf_wr = bus_req & we_i & sel_i[0]
                    & (adr_i == sp4u_pkg::SP4U_BUF_OFS);
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // (RULE23) Reads of the buffer return the receive register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            case (adr_i)
                sp4u_pkg::SP4U_CTRL_OFS: dat_reg <= {24'h00_0000, serial_control_reg};
                sp4u_pkg::SP4U_BUF_OFS: dat_reg <= {24'h00_0000, rx_buf_reg};
                sp4u_pkg::SP4U_CFG_OFS: dat_reg <= {27'h000_0000, cfg_reg};
                sp4u_pkg::SP4U_STAT_OFS:
                    dat_reg <= {29'h0000_0000, rx_state_reg != sp4u_pkg::SP4U_RX_IDLE,
                                tx_busy_reg, m0_busy_reg};
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= sp4u_pkg::SP4U_CFG_RST;
        end else if (bus_req && we_i && sel_i[0]
                     && adr_i == sp4u_pkg::SP4U_CFG_OFS) begin
            cfg_reg <= dat_i[4:0];
        end
    end

    // (RULE7) (RULE8) Hardware sets win over a software clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_control_reg <= sp4u_pkg::SP4U_CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                serial_control_reg <= dat_i[7:0];
            end
            if (rb8_load) begin
                serial_control_reg[sp4u_pkg::SP4U_RB8_BIT] <= rb8_value;
            end
            if (ti_set) begin
                serial_control_reg[sp4u_pkg::SP4U_TI_BIT] <= 1'b1;
            end
            if (ri_set) begin
                serial_control_reg[sp4u_pkg::SP4U_RI_BIT] <= 1'b1;
            end
        end
    end

    // (RULE24) Separate receive holding register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_buf_reg <= 8'h00;
        end else if (ri_set) begin
            rx_buf_reg <= rx_load_data;
        end
    end

    // ============================================================
    // Rate generation.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t1_half_reg <= 1'b0;
            fix_cnt_reg <= 2'h0;
        end else begin
            fix_cnt_reg <= fix_cnt_reg + 2'h1;
            if (timer1_ovf_i) begin
                t1_half_reg <= ~t1_half_reg;
            end
        end
    end

    // (RULE17) Fixed rate ticks every 4 or 2 cycles.
    assign fix_tick = rate_double ? fix_cnt_reg[0] : (fix_cnt_reg == 2'h3);
    assign t1_tick = timer1_ovf_i & (rate_double | t1_half_reg);
    // (RULE22) (RULE25) (RULE19) Per-direction source choice.
    assign tx_tick16 = pick_tick(mode == sp4u_pkg::SP4U_MODE_FIX9, cfg_reg[2:1],
                                 t1_tick, timer2_ovf_i, baudgen_tick_i, fix_tick);
    assign rx_tick16 = pick_tick(mode == sp4u_pkg::SP4U_MODE_FIX9, cfg_reg[4:3],
                                 t1_tick, timer2_ovf_i, baudgen_tick_i, fix_tick);

    // ============================================================
    // Receive pin synchroniser.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            rxd_prev_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd_i;
            rxd_sync_reg <= rxd_meta_reg;
            rxd_prev_reg <= rxd_sync_reg;
        end
    end

    // ============================================================
    // Shift register mode engine.
    assign m0_end = m0_busy_reg && m0_cnt_reg == sp4u_pkg::SP4U_M0_DIV - 4'h1
                    && m0_bits_reg == 3'h7;

    // (RULE9) (RULE10) (RULE11) Eight bits at core over twelve.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m0_busy_reg <= 1'b0;
            m0_rx_reg <= 1'b0;
            m0_cnt_reg <= 4'h0;
            m0_bits_reg <= 3'h0;
            m0_shift_reg <= 8'h00;
            m0_clk_reg <= 1'b1;
        end else if (mode != sp4u_pkg::SP4U_MODE_SHIFT) begin
            m0_busy_reg <= 1'b0;
            m0_clk_reg <= 1'b1;
        end else if (buf_wr) begin
            // (RULE21) Buffer write starts a shift transmit.
            m0_busy_reg <= 1'b1;
            m0_rx_reg <= 1'b0;
            m0_cnt_reg <= 4'h0;
            m0_bits_reg <= 3'h0;
            m0_shift_reg <= dat_i[7:0];
            m0_clk_reg <= 1'b0;
        end else if (!m0_busy_reg) begin
            if (rx_enable && !serial_control_reg[sp4u_pkg::SP4U_RI_BIT]
                && !ri_set) begin
                m0_busy_reg <= 1'b1;
                m0_rx_reg <= 1'b1;
                m0_cnt_reg <= 4'h0;
                m0_bits_reg <= 3'h0;
                m0_clk_reg <= 1'b0;
            end
        end else begin
            m0_cnt_reg <= m0_cnt_reg + 4'h1;
            if (m0_cnt_reg == sp4u_pkg::SP4U_M0_HALF - 4'h1) begin
                m0_clk_reg <= 1'b1;
                if (m0_rx_reg) begin
                    m0_shift_reg <= {rxd_sync_reg, m0_shift_reg[7:1]};
                end
            end
            if (m0_cnt_reg == sp4u_pkg::SP4U_M0_DIV - 4'h1) begin
                m0_cnt_reg <= 4'h0;
                m0_bits_reg <= m0_bits_reg + 3'h1;
                if (!m0_rx_reg) begin
                    m0_shift_reg <= {1'b1, m0_shift_reg[7:1]};
                end
                if (m0_bits_reg == 3'h7) begin
                    m0_busy_reg <= 1'b0;
                end else begin
                    m0_clk_reg <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // Asynchronous transmitter.
    assign tx_bits = nine_bit ? sp4u_pkg::SP4U_BITS9 : sp4u_pkg::SP4U_BITS8;
    assign tx_bit_tick = tx_tick16 && tx_sub_reg == sp4u_pkg::SP4U_OVS_LAST;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sub_reg <= 4'h0;
        end else if (tx_tick16) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
        end
    end

    // (RULE12) (RULE16) (RULE18) Frame goes out from the next bit tick.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_busy_reg <= 1'b0;
            tx_shift_reg <= 11'h7FF;
            tx_cnt_reg <= 4'h0;
            tx_line_reg <= 1'b1;
        end else if (mode == sp4u_pkg::SP4U_MODE_SHIFT) begin
            tx_busy_reg <= 1'b0;
            tx_line_reg <= 1'b1;
        end else if (buf_wr) begin
            // (RULE13) (RULE5) Ninth slot holds stop or tx ninth bit.
            tx_busy_reg <= 1'b1;
            tx_cnt_reg <= 4'h0;
            tx_shift_reg <= {1'b1, nine_bit ? tx_ninth_bit : 1'b1,
                             dat_i[7:0], 1'b0};
        end else if (tx_busy_reg && tx_bit_tick) begin
            if (tx_cnt_reg == tx_bits) begin
                tx_busy_reg <= 1'b0;
            end else begin
                tx_line_reg <= tx_shift_reg[0];
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
            end
        end
    end

    // (RULE7) Transmit done at end of bit eight or start of stop bit.
    assign ti_set = (m0_end && !m0_rx_reg)
                    || (mode != sp4u_pkg::SP4U_MODE_SHIFT && !buf_wr
                        && tx_busy_reg && tx_bit_tick
                        && tx_cnt_reg == tx_bits - 4'h1);

    // ============================================================
    // Asynchronous receiver.
    assign rx_mid = rx_tick16 && rx_sub_reg == sp4u_pkg::SP4U_OVS_MID;
    assign rx_final = rx_state_reg == sp4u_pkg::SP4U_RX_DATA && rx_mid
                      && rx_cnt_reg == (nine_bit ? sp4u_pkg::SP4U_RX_STOP9
                                                 : sp4u_pkg::SP4U_RX_STOP8);

    // (RULE14) (RULE20) (RULE26) (RULE4) Start search, check and shift.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state_reg <= sp4u_pkg::SP4U_RX_IDLE;
            rx_sub_reg <= 4'h0;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end else if (!rx_enable || mode == sp4u_pkg::SP4U_MODE_SHIFT) begin
            rx_state_reg <= sp4u_pkg::SP4U_RX_IDLE;
        end else begin
            if (rx_tick16) begin
                rx_sub_reg <= rx_sub_reg + 4'h1;
            end
            unique case (rx_state_reg)
                sp4u_pkg::SP4U_RX_IDLE: begin
                    if (rxd_prev_reg && !rxd_sync_reg) begin
                        rx_state_reg <= sp4u_pkg::SP4U_RX_START;
                        rx_sub_reg <= 4'h0;
                    end
                end
                sp4u_pkg::SP4U_RX_START: begin
                    if (rx_mid) begin
                        rx_cnt_reg <= 4'h0;
                        rx_state_reg <= rxd_sync_reg ? sp4u_pkg::SP4U_RX_IDLE
                                                     : sp4u_pkg::SP4U_RX_DATA;
                    end
                end
                sp4u_pkg::SP4U_RX_DATA: begin
                    if (rx_final) begin
                        rx_state_reg <= sp4u_pkg::SP4U_RX_IDLE;
                    end else if (rx_mid) begin
                        rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[8:1]};
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                    end
                end
                default: rx_state_reg <= sp4u_pkg::SP4U_RX_IDLE;
            endcase
        end
    end

    // (RULE6) Ninth bit, or stop bit in 8-bit mode.
    assign rb8_value = nine_bit ? rx_shift_reg[8] : rxd_sync_reg;

    // (RULE15) (RULE2) (RULE3) (RULE8) Accept only with flag clear.
    always_comb begin
        ri_set = 1'b0;
        rb8_load = 1'b0;
        rx_load_data = m0_shift_reg;
        if (m0_end && m0_rx_reg) begin
            ri_set = 1'b1;
        end else if (rx_final && rx_enable
                     && !serial_control_reg[sp4u_pkg::SP4U_RI_BIT]
                     && (!multiprocessor_enable || rb8_value)) begin
            ri_set = 1'b1;
            rb8_load = 1'b1;
            rx_load_data = nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
        end
    end

    // ============================================================
    // Pin drivers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_out_reg <= 1'b1;
            rxd_oe_reg <= 1'b0;
        end else begin
            rxd_out_reg <= m0_shift_reg[0];
            rxd_oe_reg <= m0_busy_reg && !m0_rx_reg;
        end
    end

    assign rxd_o = rxd_out_reg;
    assign rxd_oe_o = rxd_oe_reg;
    assign txd_o = (mode == sp4u_pkg::SP4U_MODE_SHIFT) ? m0_clk_reg
                                                       : tx_line_reg;

endmodule

`default_nettype wire

// ### bench/sp4u_monitor.sv
// Concurrent checks on the serial port's bus and pins.
`default_nettype none
module sp4u_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rxd_o,
    input wire logic rxd_oe_o,
    input wire logic txd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ============================================================
    // Bus checks.
    property p_ack_one; ack_o |=> !ack_o; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held longer than one cycle");
    property p_ack_due; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_due: assert property (p_ack_due)
        else $error("request not answered in one cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without a request");
    property p_rd_hold; $changed(dat_o) |-> ack_o && $past(!we_i);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved outside a read");
    property p_hi_zero; ack_o |-> dat_o[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");
    property p_unmap;
        cyc_i && stb_i && !ack_o && !we_i && adr_i[1:0] != 2'h0
            |=> dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    // ============================================================
    // Pin checks.
    property p_rst_idle; $fell(rst_i) |-> txd_o && !rxd_oe_o && !ack_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("pins not idle after reset");
    property p_low_min; $fell(txd_o) |=> !txd_o [*5]; endproperty
    a_low_min: assert property (p_low_min)
        else $error("txd low phase too short");
    property p_high_min; $rose(txd_o) |=> txd_o [*5]; endproperty
    a_high_min: assert property (p_high_min)
        else $error("txd high phase too short");
    property p_sh_hold; $changed(rxd_o) |=> $stable(rxd_o) [*8];
    endproperty
    a_sh_hold: assert property (p_sh_hold)
        else $error("shift data changed within a bit");
    c_read: cover property (ack_o && !we_i);
    c_start: cover property ($fell(txd_o));
    c_shift: cover property (rxd_oe_o && $changed(rxd_o));
endmodule

bind sp4u_top sp4u_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o)
);
`default_nettype wire

// ### bench/sp4u_peer.sv
// Remote serial device model on the receive and transmit pins.
`default_nettype none
module sp4u_peer (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic line_i,
    output logic drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial drv_o = 1'b1;
    task automatic send(input logic [10:0] b, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            drv_o <= b[i];
            repeat (p) @(posedge clk_i);
        end
        drv_o <= 1'b1;
    endtask
    task automatic grab(input int n, input int p, output logic [10:0] q);
        q = 11'h0;
        @(negedge txd_i);
        repeat (p / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            q[i] = txd_i;
            repeat (p) @(posedge clk_i);
        end
    endtask
    task automatic shq(output logic [7:0] q);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_i);
            q[i] = line_i;
        end
    endtask
    task automatic shd(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_i);
            drv_o <= d[i];
        end
        @(posedge txd_i);
        drv_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/tb_serial_port_four_mode_uart.sv
// Self-checking bench for the four-mode serial port.
`default_nettype none
module tb_serial_port_four_mode_uart;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] CT = sp4u_pkg::SP4U_CTRL_OFS;
    localparam logic [3:0] BF = sp4u_pkg::SP4U_BUF_OFS;
    localparam logic [3:0] CF = sp4u_pkg::SP4U_CFG_OFS;
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic tk = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack, txd, rxo, oe, drv;
    wire line;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    assign line = (oe === 1'b1) ? rxo : drv;
    sp4u_top u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat),
        .ack_o(ack), .timer1_ovf_i(tk), .timer2_ovf_i(tk),
        .baudgen_tick_i(tk), .rxd_i(line), .rxd_o(rxo), .rxd_oe_o(oe),
        .txd_o(txd));
    sp4u_peer u_peer (.clk_i(clk), .txd_i(txd), .line_i(line), .drv_o(drv));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tk <= ~tk;
        cyc_n <= cyc_n + 1;
        if (cyc_n == LIMIT) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, CT, 8'h00, q);
        chk("ctrl reset", 32'h0, q);
        wb(1'b0, CF, 8'h00, q);
        chk("cfg reset", 32'h0, q);
        wr(CT, 8'hE8);
        wr(4'h1, 8'hFF);
        wb(1'b0, CT, 8'h00, q);
        chk("ctrl rw", 32'hE8, q);
        wb(1'b0, 4'h2, 8'h00, q);
        chk("unmapped", 32'h0, q);
        wr(CT, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_shift();
        logic [31:0] q;
        logic [7:0] s;
        longint t0;
        longint t1;
        fork
            u_peer.shq(s);
            wr(BF, 8'h96);
            begin
                @(posedge txd);
                t0 = $time;
                @(posedge txd);
                t1 = $time;
            end
        join
        chk("shift out", 32'h96, {24'h0, s});
        chk("shift bit ns", 32'd120, 32'(t1 - t0));
        repeat (12) @(posedge clk);
        wb(1'b0, CT, 8'h00, q);
        chk("shift tx done", 32'h02, q);
        fork
            u_peer.shd(8'h5B);
            wr(CT, 8'h10);
        join
        repeat (12) @(posedge clk);
        wb(1'b0, CT, 8'h00, q);
        chk("shift rx done", 32'h11, q);
        wb(1'b0, BF, 8'h00, q);
        chk("shift rx data", 32'h5B, q);
        wr(CT, 8'h00);
        $display("test shift done");
    endtask
    task automatic t_tx();
        logic [7:0] c [5] = '{8'h40, 8'h40, 8'h88, 8'hC0, 8'h40};
        logic [7:0] f [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h04};
        int p [5] = '{64, 32, 32, 32, 32};
        logic [10:0] q;
        logic [10:0] e;
        logic [31:0] r;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            d = 8'hA5 ^ 8'(i);
            wr(CF, f[i]);
            wr(CT, c[i]);
            fork
                u_peer.grab(c[i][7] ? 11 : 10, p[i], q);
                wr(BF, d);
            join
            e = c[i][7] ? {1'b1, c[i][3], d, 1'b0} : {2'b01, d, 1'b0};
            chk("tx frame", {21'h0, e}, {21'h0, q});
            wb(1'b0, CT, 8'h00, r);
            chk("tx done", {24'h0, c[i] | 8'h02}, r);
        end
        $display("test tx done");
    endtask
    task automatic t_rx();
        logic [7:0] c [7] = '{8'h70, 8'h70, 8'hF0, 8'hF0, 8'h90, 8'h90, 8'h40};
        logic [7:0] f [7] = '{8'h10, 8'h10, 8'h08, 8'h08, 8'h00, 8'h00, 8'h10};
        int p [7] = '{32, 32, 32, 32, 64, 64, 32};
        logic [10:0] b [7] = '{11'h078, 11'h278, 11'h4B4, 11'h6B4, 11'h586,
                               11'h422, 11'h278};
        logic [7:0] e [7] = '{8'h70, 8'h75, 8'hF0, 8'hF5, 8'h91, 8'h91, 8'h40};
        logic [7:0] x [7] = '{8'h5B, 8'h3C, 8'h3C, 8'h5A, 8'hC3, 8'hC3, 8'hC3};
        logic [31:0] r;
        for (int i = 0; i < 7; i++) begin
            wr(CF, f[i]);
            if (i != 5) wr(CT, c[i]);
            u_peer.send(b[i], c[i][7] ? 11 : 10, p[i]);
            repeat (4) @(posedge clk);
            wb(1'b0, CT, 8'h00, r);
            chk("rx ctrl", {24'h0, e[i]}, r);
            wb(1'b0, BF, 8'h00, r);
            chk("rx buffer", {24'h0, x[i]}, r);
        end
        $display("test rx done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_shift();
        t_tx();
        t_rx();
        close_out();
    end
endmodule
`default_nettype wire
